// ===== include/fbsram_defs.svh
`ifndef FBSRAM_DEFS_SVH
`define FBSRAM_DEFS_SVH

// ----------------------------------------------------------------
// Geometry
// ----------------------------------------------------------------
`define ADDR_W            19
`define DEPTH             524288
`define LANES             4
`define LANE_W            8
`define DATA_W            32
`define LOW_W             2
`define HIGH_W            17

// ----------------------------------------------------------------
// Encodings and reset values
// ----------------------------------------------------------------
`define NO_LANES          4'hF
`define LOW_ZERO          2'h0
`define LOW_ONE           2'h1
`define LOW_LAST          2'h3
`define WORD_ZERO         36'h0_0000_0000
`define ADDR_ZERO         19'h0_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLK_PERIOD_NS     100
`define SLEEP_TRANS_TCYC  2
`define SLEEP_TRANS_CYC   (`SLEEP_TRANS_TCYC * `CLK_PERIOD_NS / `CLK_PERIOD_NS)
`define SLEEP_CNT_LAST    2'((`SLEEP_TRANS_CYC) - 1)
`define SLEEP_CNT_ZERO    2'h0
`define SLEEP_CNT_ONE     2'h1

`endif

// ===== include/fbsram_pkg.sv
`default_nettype none
`include "fbsram_defs.svh"

package fbsram_pkg;

  // One stored word: four lanes of eight data bits plus one parity bit each
  typedef struct packed {
    logic [`LANES-1:0]  parity;
    logic [`DATA_W-1:0] data;
  } word_t;

  // Write waiting for its data edge
  typedef struct packed {
    logic               valid;
    logic [`ADDR_W-1:0] addr;
    logic [`LANES-1:0]  lanes_n;
  } write_req_t;

  // Access kind held for a whole burst
  typedef enum logic [1:0] {
    ST_DESEL,
    ST_READ,
    ST_WRITE
  } access_t;

  // Sleep sequencing
  typedef enum logic [1:0] {
    PWR_AWAKE,
    PWR_ENTER,
    PWR_ASLEEP,
    PWR_EXIT
  } power_t;

endpackage

`default_nettype wire

// ===== hw/fbsram_core_array.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbsram_defs.svh"

module fbsram_core_array (
  input  wire logic                  clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  en_in,
  input  wire logic                  wr_in,
  input  wire logic [`ADDR_W-1:0]    wr_addr_in,
  input  wire logic [`LANES-1:0]     wr_lanes_n_in,
  input  wire fbsram_pkg::word_t     wr_word_in,
  input  wire logic                  rd_in,
  input  wire logic [`ADDR_W-1:0]    rd_addr_in,
  output fbsram_pkg::word_t          rd_word_out
);

  fbsram_pkg::word_t mem [0:`DEPTH-1];
  fbsram_pkg::word_t rd_word_q;

  // Lane-wise merge: a low select takes the new byte and its parity
  function automatic fbsram_pkg::word_t merge(input fbsram_pkg::word_t old_w,
                                              input fbsram_pkg::word_t new_w,
                                              input logic [`LANES-1:0] lanes_n);
    fbsram_pkg::word_t res;
    res = old_w;
    for (int i = 0; i < `LANES; i++) begin
      if (!lanes_n[i]) begin
        res.data[i*`LANE_W +: `LANE_W] = new_w.data[i*`LANE_W +: `LANE_W];
        res.parity[i]                  = new_w.parity[i];
      end
    end
    return res;
  endfunction

  // Byte-selective write, unselected lanes kept
  always_ff @(posedge clk_in) begin
    if (en_in && wr_in) begin
      mem[wr_addr_in] <= merge(mem[wr_addr_in], wr_word_in, wr_lanes_n_in);
    end
  end

  // Read with forwarding of a write landing on the same edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_word_q <= `WORD_ZERO;
    end else if (en_in && rd_in) begin
      if (wr_in && wr_addr_in == rd_addr_in) begin
        rd_word_q <= merge(mem[rd_addr_in], wr_word_in, wr_lanes_n_in);
      end else begin
        rd_word_q <= mem[rd_addr_in];
      end
    end
  end

  assign rd_word_out = rd_word_q;

endmodule

`default_nettype wire

// ===== hw/flowthrough_burst_sram_access.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbsram_defs.svh"

module flowthrough_burst_sram_access (
  input  wire logic                clk_in,
  input  wire logic                rst_n_in,
  input  wire logic                clk_en_in,
  input  wire logic                clock_gate_n_in,
  input  wire logic                bank_select_a_n_in,
  input  wire logic                bank_select_b_in,
  input  wire logic                bank_select_c_n_in,
  input  wire logic                advance_or_load_n_in,
  input  wire logic                write_strobe_n_in,
  input  wire logic [`LANES-1:0]   byte_lane_write_n_in,
  input  wire logic [`ADDR_W-1:0]  address_in,
  input  wire logic                output_drive_en_n_in,
  input  wire logic                sleep_request_in,
  input  wire logic                burst_order_in,
  input  wire logic [`DATA_W-1:0]  data_lines_in,
  output logic      [`DATA_W-1:0]  data_lines_out,
  output logic                     data_lines_oe_n_out,
  input  wire logic [`LANES-1:0]   parity_lines_in,
  output logic      [`LANES-1:0]   parity_lines_out,
  output logic                     parity_lines_oe_n_out,
  output logic                     sleeping_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  fbsram_pkg::access_t    state_q;
  fbsram_pkg::power_t     pwr_q;
  fbsram_pkg::write_req_t wr_pend_q;
  fbsram_pkg::word_t      bus_word;
  fbsram_pkg::word_t      rd_word;
  logic [`HIGH_W-1:0]     base_q;
  logic [`LOW_W-1:0]      start_q;
  logic [`LOW_W-1:0]      cnt_q;
  logic [1:0]             sleep_cnt_q;
  logic                   sleep_meta_q;
  logic                   sleep_sync_q;
  logic                   strap_meta_q;
  logic                   strap_sync_q;
  logic                   strap_taken_q;
  logic [1:0]             strap_age_q;
  logic                   interleave_q;
  logic                   first_q;
  logic                   awake;
  logic                   en;
  logic                   load;
  logic                   selected;
  logic                   start_read;
  logic                   start_write;
  logic                   new_read;
  logic                   new_write;
  logic                   mem_wr;
  logic [`LOW_W-1:0]      next_cnt;
  logic [`ADDR_W-1:0]     cur_addr;
  logic                   drive;

  // Burst address low bits from start value and beat count
  function automatic logic [`LOW_W-1:0] burst_low(input logic [`LOW_W-1:0] start,
                                                  input logic [`LOW_W-1:0] beat,
                                                  input logic              interleave);
    if (interleave) begin
      return start ^ beat;
    end
    return `LOW_W'(start + beat);
  endfunction

  // ----------------------------------------------------------------
  // Command decode
  // ----------------------------------------------------------------
  // Edge qualifier and load decode
  assign awake       = (pwr_q == fbsram_pkg::PWR_AWAKE);
  assign en          = clk_en_in && !clock_gate_n_in && awake;
  assign load        = !advance_or_load_n_in;
  assign selected    = !bank_select_a_n_in && bank_select_b_in && !bank_select_c_n_in;
  assign start_read  = load && selected && write_strobe_n_in;
  assign start_write = load && selected && !write_strobe_n_in;
  assign next_cnt    = `LOW_W'(cnt_q + `LOW_ONE);

  // Address of this beat, fresh on a load, counted on an advance
  assign cur_addr = load ? address_in
                         : {base_q, burst_low(start_q, next_cnt, interleave_q)};

  // Access kind of this beat, direction held through the burst
  assign new_read  = start_read || (!load && state_q == fbsram_pkg::ST_READ);
  assign new_write = start_write || (!load && state_q == fbsram_pkg::ST_WRITE);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Sleep request is asynchronous
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sleep_meta_q <= 1'b0;
      sleep_sync_q <= 1'b0;
    end else if (clk_en_in) begin
      sleep_meta_q <= sleep_request_in;
      sleep_sync_q <= sleep_meta_q;
    end
  end

  // Burst order strap, caught once the synchroniser holds the pin level
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      strap_meta_q  <= 1'b0;
      strap_sync_q  <= 1'b0;
      strap_age_q   <= '0;
      strap_taken_q <= 1'b0;
      interleave_q  <= 1'b0;
    end else if (clk_en_in) begin
      strap_meta_q <= burst_order_in;
      strap_sync_q <= strap_meta_q;
      strap_age_q  <= {strap_age_q[0], 1'b1};
      if (strap_age_q[1] && !strap_taken_q) begin
        strap_taken_q <= 1'b1;
        interleave_q  <= strap_sync_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Sleep sequencing
  // ----------------------------------------------------------------
  // Two cycles to enter, two to leave
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pwr_q       <= fbsram_pkg::PWR_AWAKE;
      sleep_cnt_q <= `SLEEP_CNT_ZERO;
    end else if (clk_en_in) begin
      case (pwr_q)
        fbsram_pkg::PWR_AWAKE: begin
          sleep_cnt_q <= `SLEEP_CNT_ZERO;
          if (sleep_sync_q) begin
            pwr_q <= fbsram_pkg::PWR_ENTER;
          end
        end
        fbsram_pkg::PWR_ENTER: begin
          sleep_cnt_q <= `SLEEP_CNT_ONE;
          if (sleep_cnt_q == `SLEEP_CNT_LAST) begin
            pwr_q       <= fbsram_pkg::PWR_ASLEEP;
            sleep_cnt_q <= `SLEEP_CNT_ZERO;
          end
        end
        fbsram_pkg::PWR_ASLEEP: begin
          if (!sleep_sync_q) begin
            pwr_q <= fbsram_pkg::PWR_EXIT;
          end
        end
        fbsram_pkg::PWR_EXIT: begin
          sleep_cnt_q <= `SLEEP_CNT_ONE;
          if (sleep_cnt_q == `SLEEP_CNT_LAST) begin
            pwr_q       <= fbsram_pkg::PWR_AWAKE;
            sleep_cnt_q <= `SLEEP_CNT_ZERO;
          end
        end
        default: begin
          pwr_q <= fbsram_pkg::PWR_AWAKE;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Access state and burst counter
  // ----------------------------------------------------------------
  // Access kind; sleep drops any access in flight
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= fbsram_pkg::ST_DESEL;
    end else if (clk_en_in && !awake) begin
      state_q <= fbsram_pkg::ST_DESEL;
    end else if (en && load) begin
      if (!selected) begin
        state_q <= fbsram_pkg::ST_DESEL;
      end else if (write_strobe_n_in) begin
        state_q <= fbsram_pkg::ST_READ;
      end else begin
        state_q <= fbsram_pkg::ST_WRITE;
      end
    end
  end

  // Address load and count; advance ignores selects and strobe
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      base_q  <= `HIGH_W'(`ADDR_ZERO);
      start_q <= `LOW_ZERO;
      cnt_q   <= `LOW_ZERO;
    end else if (en) begin
      if (load && selected) begin
        base_q  <= address_in[`ADDR_W-1:`LOW_W];
        start_q <= address_in[`LOW_W-1:0];
        cnt_q   <= `LOW_ZERO;
      end else if (!load) begin
        cnt_q <= next_cnt;
      end
    end
  end

  // Marks the first cycle after leaving deselect
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      first_q <= 1'b0;
    end else if (en) begin
      first_q <= (state_q == fbsram_pkg::ST_DESEL) && load && selected;
    end
  end

  // ----------------------------------------------------------------
  // Write data phase
  // ----------------------------------------------------------------
  // Lane selects of each beat are held for the following data edge
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wr_pend_q <= '0;
    end else if (clk_en_in && !awake) begin
      wr_pend_q <= '0;
    end else if (en) begin
      wr_pend_q.valid   <= new_write;
      wr_pend_q.addr    <= cur_addr;
      wr_pend_q.lanes_n <= byte_lane_write_n_in;
    end
  end

  // All lane selects high aborts the write
  assign mem_wr        = en && wr_pend_q.valid && (wr_pend_q.lanes_n != `NO_LANES);
  assign bus_word.data   = data_lines_in;
  assign bus_word.parity = parity_lines_in;

  // Storage with flow-through read register
  fbsram_core_array u_array (
    .clk_in        (clk_in),
    .rst_n_in      (rst_n_in),
    .en_in         (en),
    .wr_in         (mem_wr),
    .wr_addr_in    (wr_pend_q.addr),
    .wr_lanes_n_in (wr_pend_q.lanes_n),
    .wr_word_in    (bus_word),
    .rd_in         (new_read),
    .rd_addr_in    (cur_addr),
    .rd_word_out   (rd_word)
  );

  // ----------------------------------------------------------------
  // Output drivers
  // ----------------------------------------------------------------
  // Drive only in a read beat, awake, past the first cycle, enable low
  assign drive = (state_q == fbsram_pkg::ST_READ) && awake && !first_q
                 && !output_drive_en_n_in;

  assign data_lines_out        = rd_word.data;
  assign parity_lines_out      = rd_word.parity;
  assign data_lines_oe_n_out   = !drive;
  assign parity_lines_oe_n_out = !drive;
  assign sleeping_out          = (pwr_q == fbsram_pkg::PWR_ASLEEP);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);

  stall_hold_a: assert property (
    clk_en_in && clock_gate_n_in && awake |=> $stable(state_q) && $stable(cnt_q) && $stable(base_q))
    else $error("access state changed on an ignored edge");

  read_start_a: assert property (
    en && start_read |=> state_q == fbsram_pkg::ST_READ && cnt_q == `LOW_ZERO)
    else $error("read load did not start a read");

  read_drive_a: assert property (
    en && start_read && state_q != fbsram_pkg::ST_DESEL ##1 awake && !output_drive_en_n_in
    |-> !data_lines_oe_n_out && !parity_lines_oe_n_out)
    else $error("read data not driven in the cycle after the edge");

  desel_float_a: assert property (
    en && load && !selected
    |=> state_q == fbsram_pkg::ST_DESEL && data_lines_oe_n_out && parity_lines_oe_n_out)
    else $error("bus driven after a deselect");

  burst_wrap_a: assert property (
    en && !load && cnt_q == `LOW_LAST |=> cnt_q == `LOW_ZERO)
    else $error("burst counter did not wrap");

  burst_order_a: assert property (
    en && start_read ##1 en && !load |-> cur_addr[`LOW_W-1:0]
    == (interleave_q ? ($past(address_in[`LOW_W-1:0]) ^ `LOW_ONE)
                     : `LOW_W'($past(address_in[`LOW_W-1:0]) + `LOW_ONE)))
    else $error("second beat address wrong");

  dir_keep_a: assert property (
    en && !load && state_q == fbsram_pkg::ST_WRITE && awake |=> state_q == fbsram_pkg::ST_WRITE)
    else $error("write burst changed direction");

  write_float_a: assert property (
    state_q == fbsram_pkg::ST_WRITE |-> data_lines_oe_n_out && parity_lines_oe_n_out)
    else $error("bus driven in a write data phase");

  write_commit_a: assert property (
    en && start_write && byte_lane_write_n_in != `NO_LANES ##1 en |-> mem_wr)
    else $error("write data not stored on the next edge");

  abort_none_a: assert property (
    wr_pend_q.valid && wr_pend_q.lanes_n == `NO_LANES |-> !mem_wr)
    else $error("aborted write modified memory");

  sleep_entry_a: assert property (
    pwr_q == fbsram_pkg::PWR_AWAKE && sleep_sync_q && clk_en_in ##1 clk_en_in ##1 clk_en_in
    |=> pwr_q == fbsram_pkg::PWR_ASLEEP)
    else $error("sleep entry did not take two cycles");

  sleep_float_a: assert property (
    !awake |-> data_lines_oe_n_out && parity_lines_oe_n_out
               && (state_q == fbsram_pkg::ST_DESEL || $past(awake) || !$past(clk_en_in)))
    else $error("bus driven while asleep");

  first_float_a: assert property (
    first_q |-> data_lines_oe_n_out)
    else $error("bus driven in first cycle after deselect");

  read_burst_c: cover property (en && start_read ##1 (en && !load) [*3]);
  write_burst_c: cover property (en && start_write ##1 (en && !load) [*3]);
  sleep_cycle_c: cover property (pwr_q == fbsram_pkg::PWR_ASLEEP ##[1:20] awake);
  stall_edge_c: cover property (state_q == fbsram_pkg::ST_READ && clock_gate_n_in && clk_en_in);

endmodule

`default_nettype wire

// ===== tb/bus_master_model.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbsram_defs.svh"

module bus_master_model (
  input  wire logic               clk_in,
  input  wire fbsram_pkg::word_t  dev_word_in,
  input  wire logic               dev_oe_n_in,
  output logic                    gate_n_out,
  output logic      [2:0]         sel_out,
  output logic                    load_n_out,
  output logic                    we_n_out,
  output logic      [`LANES-1:0]  lanes_n_out,
  output logic      [`ADDR_W-1:0] addr_out,
  output var fbsram_pkg::word_t   bus_out
);
  fbsram_pkg::word_t last_q   = `WORD_ZERO;
  fbsram_pkg::word_t wr_word  = `WORD_ZERO;
  logic              wr_drive = 1'b0;

  // ----------------------------------------------------------------
  // Shared wire
  // ----------------------------------------------------------------
  // Device, master, or a drifting pattern once both let go
  assign bus_out = !dev_oe_n_in ? dev_word_in : (wr_drive ? wr_word : ~last_q);

  // Last level seen on the wire
  always @(posedge clk_in) begin
    last_q <= bus_out;
  end

  // ----------------------------------------------------------------
  // Bus cycle
  // ----------------------------------------------------------------
  // Set up after an edge, hold through the next edge
  task automatic cmd(input logic gate_n, input logic load_n, input logic [2:0] sel, input logic we_n,
                     input logic [`LANES-1:0] lanes_n, input logic [`ADDR_W-1:0] addr,
                     input logic drive, input fbsram_pkg::word_t word);
    gate_n_out  = gate_n;
    load_n_out  = load_n;
    sel_out     = sel;
    we_n_out    = we_n;
    lanes_n_out = lanes_n;
    addr_out    = addr;
    wr_drive    = drive;
    wr_word     = word;
    @(posedge clk_in);
    #1;
  endtask
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "fbsram_defs.svh"

module tb_top;
  logic                clk_in    = 1'b0;
  logic                rst_n     = 1'b0;
  logic                clk_en    = 1'b1;
  logic                oe_req_n  = 1'b0;
  logic                sleep_req = 1'b0;
  logic                order     = 1'b0;
  logic                gate_n, load_n, we_n, doe_n, poe_n, sleeping, pw;
  logic [2:0]          sel, dsel;
  logic [`LANES-1:0]   lanes_n, dpar, pw_lanes;
  logic [`ADDR_W-1:0]  addr, base, start, pw_addr;
  logic [`DATA_W-1:0]  dout;
  fbsram_pkg::word_t   bus;
  fbsram_pkg::word_t   mem [int];
  int                  failures = 0;
  int                  n_checks = 0;
  int                  seed     = 70;
  int                  cycles   = 0;
  int                  kind, prev, beat;

  // Clock
  initial begin
    forever #50 clk_in = ~clk_in;
  end

  bus_master_model i_master (
    .clk_in(clk_in), .dev_word_in({dpar, dout}), .dev_oe_n_in(doe_n), .gate_n_out(gate_n),
    .sel_out(sel), .load_n_out(load_n), .we_n_out(we_n), .lanes_n_out(lanes_n),
    .addr_out(addr), .bus_out(bus)
  );

  flowthrough_burst_sram_access i_dut (
    .clk_in(clk_in), .rst_n_in(rst_n), .clk_en_in(clk_en), .clock_gate_n_in(gate_n),
    .bank_select_a_n_in(sel[2]), .bank_select_b_in(sel[1]), .bank_select_c_n_in(sel[0]),
    .advance_or_load_n_in(load_n), .write_strobe_n_in(we_n), .byte_lane_write_n_in(lanes_n),
    .address_in(addr), .output_drive_en_n_in(oe_req_n), .sleep_request_in(sleep_req),
    .burst_order_in(order), .data_lines_in(bus.data), .data_lines_out(dout),
    .data_lines_oe_n_out(doe_n), .parity_lines_in(bus.parity), .parity_lines_out(dpar),
    .parity_lines_oe_n_out(poe_n), .sleeping_out(sleeping)
  );

  // Compare and count
  task automatic check(input string what, input logic [35:0] seen, input logic [35:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // Counts and verdict
  task automatic finish_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // One access edge, mirrored in the bench model
  task automatic op(input logic ld_n, input logic [2:0] s, input logic wn, input logic [3:0] ln,
                    input logic [`ADDR_W-1:0] a);
    fbsram_pkg::word_t  w;
    logic [`ADDR_W-1:0] cur;
    logic               drv;
    w = 36'({$random(seed), $random(seed)});
    for (int i = 0; i < `LANES; i++) begin
      if (pw && !pw_lanes[i]) begin
        mem[pw_addr].data[i*8 +: 8] = w.data[i*8 +: 8];
        mem[pw_addr].parity[i] = w.parity[i];
      end
    end
    i_master.cmd(1'b0, ld_n, s, wn, ln, a, pw, w);
    prev = kind;
    beat = ld_n ? (beat + 1) % 4 : 0;
    if (!ld_n) begin
      kind = (s != 3'h2) ? 0 : (wn ? 1 : 2);
      start = a;
    end
    cur = {start[18:2], order ? start[1:0] ^ 2'(beat) : start[1:0] + 2'(beat)};
    pw = (kind == 2);
    pw_addr = cur;
    pw_lanes = ln;
    drv = (kind == 1) && (prev != 0) && !oe_req_n;
    check("data oe_n", 36'(doe_n), 36'(!drv));
    check("parity oe_n", 36'(poe_n), 36'(!drv));
    if (drv) begin
      check("read word", {dpar, dout}, mem[cur]);
    end
  endtask

  // Edge ignored through the qualifier or the clock enable
  task automatic stall();
    fbsram_pkg::word_t was;
    logic              oe_was;
    was = {dpar, dout};
    oe_was = doe_n;
    clk_en = 1'($random(seed));
    i_master.cmd(clk_en, 1'b0, 3'h2, 1'b0, 4'h0, 19'($random(seed)), 1'b0, `WORD_ZERO);
    clk_en = 1'b1;
    check("stalled word", {dpar, dout}, was);
    check("stalled oe_n", 36'(doe_n), 36'(oe_was));
  endtask

  // Reset with the strap set, then idle deselected
  task automatic reset(input logic mode);
    order = mode;
    rst_n = 1'b0;
    kind = 0;
    pw = 1'b0;
    repeat (3) i_master.cmd(1'b0, 1'b0, 3'h7, 1'b1, 4'hF, `ADDR_ZERO, 1'b0, `WORD_ZERO);
    rst_n = 1'b1;
    check("reset state", 36'({doe_n, poe_n, sleeping}), 36'h6);
    repeat (4) op(1'b0, 3'h7, 1'b1, 4'hF, `ADDR_ZERO);
  endtask

  // Main sequence, once per burst order
  initial begin
    for (int m = 0; m < 2; m++) begin
      reset(1'(m));
      base = 19'($random(seed));
      // Burst write, noise on selects and strobe during advances
      op(1'b0, 3'h2, 1'b0, 4'h0, base);
      repeat (3) op(1'b1, 3'($random(seed)), 1'($random(seed)), 4'h0, 19'($random(seed)));
      // Read burst from a random start, wrapping once, with a stall
      op(1'b0, 3'h2, 1'b1, 4'hF, {base[18:2], 2'($random(seed))});
      stall();
      repeat (4) op(1'b1, 3'($random(seed)), 1'b0, 4'hF, `ADDR_ZERO);
      $display("burst test done");
      // Every lane pattern back to back, then read back
      for (int p = 0; p < 16; p++) begin
        op(1'b0, 3'h2, 1'b0, 4'(p), {base[18:2], 2'(p)});
      end
      op(1'b0, 3'h2, 1'b1, 4'hF, base);
      repeat (3) op(1'b1, 3'h2, 1'b1, 4'hF, `ADDR_ZERO);
      $display("lane test done");
      // Dummy read, output enable back mid-burst
      oe_req_n = 1'b1;
      op(1'b0, 3'h2, 1'b1, 4'hF, base);
      op(1'b1, 3'h2, 1'b1, 4'hF, base);
      oe_req_n = 1'b0;
      op(1'b1, 3'h2, 1'b1, 4'hF, base);
      // Deselect, advance while deselected, reload
      dsel = 3'($random(seed));
      if (dsel == 3'h2) begin
        dsel = 3'h0;
      end
      op(1'b0, dsel, 1'b1, 4'hF, base);
      op(1'b1, 3'h2, 1'b1, 4'hF, base);
      op(1'b0, 3'h2, 1'b1, 4'hF, base);
      op(1'b1, 3'h2, 1'b1, 4'hF, base);
      $display("deselect test done");
      // Sleep while deselected, wake, read back
      op(1'b0, dsel, 1'b1, 4'hF, base);
      sleep_req = 1'b1;
      for (int k = 0; k < 8 && sleeping !== 1'b1; k++) begin
        op(1'b0, dsel, 1'b0, 4'h0, base);
      end
      check("asleep", 36'({sleeping, doe_n}), 36'h3);
      sleep_req = 1'b0;
      repeat (6) op(1'b0, dsel, 1'b1, 4'hF, base);
      check("awake", 36'(sleeping), 36'h0);
      op(1'b0, 3'h2, 1'b1, 4'hF, base);
      repeat (3) op(1'b1, 3'h2, 1'b1, 4'hF, base);
      $display("sleep test done");
    end
    finish_test();
  end

  // Hang guard
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      finish_test();
    end
  end
endmodule
`default_nettype wire
